// ### rtl/aec_audio_ctrl.sv
// Audio engine control: register file, synthesizer control, sample playback.
// Assumes sample RAM and the synthesizer sit on the same clock as this block.
`timescale 1ns/100ps
// Contract
// R1: Sound select low byte chooses the synthesized effect.
// R2: High byte is the MIDI note; non-pitched effects ignore it.
// R3: Synth output scaled by 8-bit volume, reset 0xFF, zero mutes.
// R4: Playback output scaled by separate 8-bit volume, reset 0xFF, zero mutes.
// R5: Any write to playback trigger bit zero starts playback.
// R6: Trigger bit reads one while playing, zero when done.
// R7: Loop set restarts from start address after all data; else stop.
// R8: Format 00 linear, 01 uLaw, 10 IMA ADPCM, 11 undefined.
// R9: Synth play write starts effect; bit reads one while playing.
// R10: Fetch from 20-bit start address for 20-bit byte length.
// R11: Read-only 20-bit pointer shows address being played.
// R12: Samples paced at 16-bit rate in hertz, reset 8000.
// R13: Volume applies linearly as sample times volume over 255.
module aec_audio_ctrl (
  input wire logic sys_clk_in,
  input wire logic rst_b_in,
  input wire logic [7:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  input wire logic [3:0] avs_byteenable_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  output aec_pkg::aec_ram_req_type ram_req_out,
  input wire logic ram_valid_in,
  input wire logic [7:0] ram_data_in,
  output logic [7:0] synth_effect_out,
  output logic [7:0] synth_note_out,
  output logic synth_play_out,
  input wire logic synth_busy_in,
  input wire logic synth_sample_valid_in,
  input wire logic [15:0] synth_sample_in,
  output aec_pkg::aec_sample_type synth_sample_out,
  output aec_pkg::aec_sample_type pb_sample_out
);
  logic ack;
  logic [31:0] rdata;
  logic [7:0] pb_vol, syn_vol;
  logic [15:0] sound;
  logic [15:0] rate;
  logic [19:0] start, len;
  logic [1:0] fmt;
  logic loop_en;
  logic syn_play;
  aec_pkg::aec_sample_type syn_out;
  aec_pkg::aec_pb_state_type state;
  logic [19:0] ptr, remain;
  logic [25:0] acc;
  logic [7:0] cur_byte;
  logic nib;

  logic next_ack;
  logic [31:0] next_rdata;
  logic [7:0] next_pb_vol, next_syn_vol;
  logic [15:0] next_sound;
  logic [15:0] next_rate;
  logic [19:0] next_start, next_len;
  logic [1:0] next_fmt;
  logic next_loop_en;
  logic next_syn_play;
  aec_pkg::aec_sample_type next_syn_out;
  aec_pkg::aec_pb_state_type next_state;
  logic [19:0] next_ptr, next_remain;
  logic [25:0] next_acc;
  logic [7:0] next_cur_byte;
  logic next_nib;

  logic take, wr_go, trigger, tick, dec_step, dec_restart, consume, last;

  // One wait cycle per access keeps read data registered
  assign take = (avs_read_in | avs_write_in) & ~ack;
  assign avs_waitrequest_out = take;
  assign wr_go = avs_write_in & ack;
  assign avs_readdata_out = rdata;
  // R1: effect byte, R2: note byte
  assign synth_effect_out = sound[aec_pkg::SND_EFFECT_LSB +: 8];
  assign synth_note_out = sound[aec_pkg::SND_NOTE_LSB +: 8];
  assign synth_play_out = syn_play;
  assign synth_sample_out = syn_out;
  assign ram_req_out.req = (state == aec_pkg::PB_FETCH);
  assign ram_req_out.addr = ptr;

  // Register file and bus answer
  always_comb
  begin
    logic [31:0] wv;
    logic [31:0] cur;
    wv = 32'h00000000;
    cur = 32'h00000000;
    next_ack = take;
    next_pb_vol = pb_vol;
    next_syn_vol = syn_vol;
    next_sound = sound;
    next_rate = rate;
    next_start = start;
    next_len = len;
    next_fmt = fmt;
    next_loop_en = loop_en;
    next_syn_play = 1'b0;
    trigger = 1'b0;
    unique case (avs_address_in)
      aec_pkg::OFS_PB_VOL: cur = {24'h000000, pb_vol};
      aec_pkg::OFS_SYN_VOL: cur = {24'h000000, syn_vol};
      aec_pkg::OFS_SOUND: cur = {16'h0000, sound};
      // R9: busy while effect plays
      aec_pkg::OFS_SYN_PLAY: cur = {31'h00000000, synth_busy_in | syn_play};
      aec_pkg::OFS_PB_START: cur = {12'h000, start};
      aec_pkg::OFS_PB_LEN: cur = {12'h000, len};
      // R11: live read pointer
      aec_pkg::OFS_PB_PTR: cur = {12'h000, ptr};
      aec_pkg::OFS_PB_RATE: cur = {16'h0000, rate};
      aec_pkg::OFS_PB_FMT: cur = {30'h00000000, fmt};
      aec_pkg::OFS_PB_LOOP: cur = {31'h00000000, loop_en};
      // R6: playback status readback
      aec_pkg::OFS_PB_PLAY: cur = {31'h00000000, state != aec_pkg::PB_IDLE};
      default: cur = 32'h00000000;
    endcase
    next_rdata = (take & avs_read_in) ? cur : rdata;
    if (wr_go)
    begin
      wv = aec_pkg::be_merge(cur, avs_writedata_in, avs_byteenable_in);
      unique case (avs_address_in)
        aec_pkg::OFS_PB_VOL: next_pb_vol = wv[7:0];
        aec_pkg::OFS_SYN_VOL: next_syn_vol = wv[7:0];
        aec_pkg::OFS_SOUND: next_sound = wv[15:0];
        // R9: play pulse on any write with byte lane 0 enabled
        aec_pkg::OFS_SYN_PLAY: next_syn_play = avs_byteenable_in[0];
        aec_pkg::OFS_PB_START: next_start = wv[19:0];
        aec_pkg::OFS_PB_LEN: next_len = wv[19:0];
        aec_pkg::OFS_PB_RATE: next_rate = wv[15:0];
        aec_pkg::OFS_PB_FMT: next_fmt = wv[1:0];
        aec_pkg::OFS_PB_LOOP: next_loop_en = wv[0];
        // R5: value written does not matter
        aec_pkg::OFS_PB_PLAY: trigger = avs_byteenable_in[0];
        default: next_syn_play = 1'b0;
      endcase
    end
  end

  // Synthesizer output scaling
  always_comb
  begin
    next_syn_out.valid = synth_sample_valid_in;
    // R3: synth volume
    next_syn_out.data = synth_sample_valid_in ?
      aec_pkg::scale_volume(synth_sample_in, syn_vol) : syn_out.data;
  end

  // Playback sequencer
  always_comb
  begin
    logic [26:0] sum;
    // R12: rate accumulator, one tick per 1/rate seconds
    sum = {1'b0, acc} + {11'h000, rate};
    // A tick due while fetching waits for the byte instead of being lost
    tick = (state == aec_pkg::PB_EMIT) && (sum >= {1'b0, aec_pkg::CLK_HZ});
    next_acc = tick ? 26'(sum - {1'b0, aec_pkg::CLK_HZ}) : sum[25:0];
    if (state == aec_pkg::PB_IDLE || (!tick && sum >= {1'b0, aec_pkg::CLK_HZ}))
    begin
      next_acc = (state == aec_pkg::PB_IDLE) ? 26'h0000000 : acc;
    end
    next_state = state;
    next_ptr = ptr;
    next_remain = remain;
    next_cur_byte = cur_byte;
    next_nib = nib;
    dec_step = 1'b0;
    dec_restart = 1'b0;
    consume = 1'b0;
    last = (remain == 20'h00001);
    unique case (state)
      aec_pkg::PB_IDLE: next_state = aec_pkg::PB_IDLE;
      aec_pkg::PB_FETCH:
      begin
        if (ram_valid_in)
        begin
          next_cur_byte = ram_data_in;
          next_nib = 1'b0;
          next_state = aec_pkg::PB_EMIT;
        end
      end
      aec_pkg::PB_EMIT:
      begin
        if (tick)
        begin
          dec_step = 1'b1;
          // ADPCM bytes carry two samples, low nibble first
          if (fmt == aec_pkg::FMT_ADPCM && !nib)
          begin
            next_nib = 1'b1;
          end
          else
          begin
            consume = 1'b1;
            // R10: walk through the byte length
            next_ptr = ptr + 20'h00001;
            next_remain = remain - 20'h00001;
            next_state = aec_pkg::PB_FETCH;
            if (last)
            begin
              next_state = aec_pkg::PB_IDLE;
              // R7: loop back to start
              if (loop_en && len != 20'h00000)
              begin
                next_ptr = start;
                next_remain = len;
                dec_restart = 1'b1;
                next_state = aec_pkg::PB_FETCH;
              end
            end
          end
        end
      end
    endcase
    // R5: a new trigger restarts even a running playback
    if (trigger)
    begin
      next_ptr = start;
      next_remain = len;
      dec_restart = 1'b1;
      next_acc = 26'h0000000;
      next_state = (len == 20'h00000) ? aec_pkg::PB_IDLE : aec_pkg::PB_FETCH;
    end
  end

  always_ff @(posedge sys_clk_in)
  begin
    if (!rst_b_in)
    begin
      ack <= 1'b0;
      rdata <= 32'h00000000;
      pb_vol <= aec_pkg::RST_VOL;
      syn_vol <= aec_pkg::RST_VOL;
      sound <= aec_pkg::RST_SOUND;
      rate <= aec_pkg::RST_RATE;
      start <= aec_pkg::RST_ADDR;
      len <= aec_pkg::RST_ADDR;
      fmt <= aec_pkg::RST_FMT;
      loop_en <= aec_pkg::RST_LOOP;
      syn_play <= 1'b0;
      syn_out <= '0;
      state <= aec_pkg::PB_IDLE;
      ptr <= aec_pkg::RST_ADDR;
      remain <= aec_pkg::RST_ADDR;
      acc <= 26'h0000000;
      cur_byte <= 8'h00;
      nib <= 1'b0;
    end
    else
    begin
      ack <= next_ack;
      rdata <= next_rdata;
      pb_vol <= next_pb_vol;
      syn_vol <= next_syn_vol;
      sound <= next_sound;
      rate <= next_rate;
      start <= next_start;
      len <= next_len;
      fmt <= next_fmt;
      loop_en <= next_loop_en;
      syn_play <= next_syn_play;
      syn_out <= next_syn_out;
      state <= next_state;
      ptr <= next_ptr;
      remain <= next_remain;
      acc <= next_acc;
      cur_byte <= next_cur_byte;
      nib <= next_nib;
    end
  end

  aec_sample_decode u_decode (
    .sys_clk_in(sys_clk_in),
    .rst_b_in(rst_b_in),
    .format_in(fmt),
    .byte_in(cur_byte),
    .nibble_hi_in(nib),
    .step_in(dec_step),
    .restart_in(dec_restart),
    .volume_in(pb_vol),
    .sample_out(pb_sample_out)
  );

  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (!rst_b_in);

  a_effect_follows: assert property (wr_go && avs_address_in == aec_pkg::OFS_SOUND // R1
    && avs_byteenable_in[0] |=> synth_effect_out == $past(avs_writedata_in[7:0]))
    else $error("effect select not taken");
  a_note_follows: assert property (wr_go && avs_address_in == aec_pkg::OFS_SOUND // R2
    && avs_byteenable_in[1] |=> synth_note_out == $past(avs_writedata_in[15:8]))
    else $error("note not taken");
  a_synth_mute: assert property (synth_sample_valid_in && syn_vol == 8'h00 // R3
    |=> synth_sample_out.valid && synth_sample_out.data == 16'h0000)
    else $error("synth not muted");
  a_synth_full: assert property (synth_sample_valid_in && syn_vol == 8'hFF // R13
    |=> synth_sample_out.data == $past(synth_sample_in))
    else $error("full synth volume altered sample");
  a_pb_mute: assert property (dec_step && pb_vol == 8'h00 // R4
    |=> pb_sample_out.valid && pb_sample_out.data == 16'h0000)
    else $error("playback not muted");
  a_trigger_start: assert property (trigger && len != 20'h00000 // R5
    |=> state == aec_pkg::PB_FETCH && ptr == $past(start) && remain == $past(len))
    else $error("trigger did not start playback");
  a_play_readback: assert property (take && avs_read_in // R6
    && avs_address_in == aec_pkg::OFS_PB_PLAY
    |=> avs_readdata_out[0] == ($past(state) != aec_pkg::PB_IDLE) && !avs_waitrequest_out)
    else $error("playback status wrong");
  a_loop_restart: assert property (consume && last && loop_en && !trigger // R7
    && len != 20'h00000 |=> ptr == $past(start) && state == aec_pkg::PB_FETCH)
    else $error("loop did not restart");
  a_loop_off_end: assert property (consume && last && !loop_en && !trigger // R7
    |=> state == aec_pkg::PB_IDLE ##1 ram_req_out.req == 1'b0)
    else $error("playback did not end");
  a_undef_silent: assert property (dec_step && fmt == aec_pkg::FMT_UNDEF // R8
    |=> pb_sample_out.data == 16'h0000)
    else $error("undefined format not silent");
  a_synth_play: assert property (wr_go && avs_address_in == aec_pkg::OFS_SYN_PLAY // R9
    && avs_byteenable_in[0] |=> synth_play_out ##1 !synth_play_out)
    else $error("synth play pulse wrong");
  a_fetch_bound: assert property (ram_req_out.req |-> remain != 20'h00000 // R10
    && ram_req_out.addr == ptr)
    else $error("fetch past length");
  a_ptr_advance: assert property (consume && !last && !trigger // R11
    |=> ptr == $past(ptr) + 20'h00001)
    else $error("pointer did not advance");
  a_rate_spacing: assert property (dec_step |=> !dec_step [*8]) // R12
    else $error("samples faster than rate allows");

  c_trigger: cover property (trigger ##1 state == aec_pkg::PB_FETCH);
  c_loop: cover property (consume && last && loop_en);
  c_adpcm_pair: cover property (dec_step && nib && fmt == aec_pkg::FMT_ADPCM);
  c_synth_play: cover property (synth_play_out);
endmodule

// ### rtl/aec_pkg.sv
// Audio engine control: register map, reset values, types, shared functions.
// Assumes one 40 MHz system clock and a byte-addressed Avalon-MM slave port.
package aec_pkg;
  // Clock rate, used to pace samples at the programmed rate
  localparam int CLK_PERIOD_NS = 25;
  localparam logic [25:0] CLK_HZ = 26'(1_000_000_000 / CLK_PERIOD_NS);

  // Register byte offsets
  localparam logic [7:0] OFS_PB_VOL = 8'h80;
  localparam logic [7:0] OFS_SYN_VOL = 8'h84;
  localparam logic [7:0] OFS_SOUND = 8'h88;
  localparam logic [7:0] OFS_SYN_PLAY = 8'h8C;
  localparam logic [7:0] OFS_PB_START = 8'hB4;
  localparam logic [7:0] OFS_PB_LEN = 8'hB8;
  localparam logic [7:0] OFS_PB_PTR = 8'hBC;
  localparam logic [7:0] OFS_PB_RATE = 8'hC0;
  localparam logic [7:0] OFS_PB_FMT = 8'hC4;
  localparam logic [7:0] OFS_PB_LOOP = 8'hC8;
  localparam logic [7:0] OFS_PB_PLAY = 8'hCC;

  // Field positions
  localparam int SND_EFFECT_LSB = 0;
  localparam int SND_NOTE_LSB = 8;
  localparam int PLAY_BIT = 0;

  // Reset values
  localparam logic [7:0] RST_VOL = 8'hFF;
  localparam logic [15:0] RST_SOUND = 16'h0000;
  localparam logic [15:0] RST_RATE = 16'h1F40;
  localparam logic [19:0] RST_ADDR = 20'h00000;
  localparam logic [1:0] RST_FMT = 2'h0;
  localparam logic RST_LOOP = 1'b0;

  typedef enum logic [1:0] {
    FMT_LINEAR = 2'h0,
    FMT_ULAW = 2'h1,
    FMT_ADPCM = 2'h2,
    FMT_UNDEF = 2'h3
  } aec_fmt_type;

  typedef enum logic [1:0] {
    PB_IDLE = 2'h0,
    PB_FETCH = 2'h1,
    PB_EMIT = 2'h3
  } aec_pb_state_type;

  typedef struct packed {
    logic req;
    logic [19:0] addr;
  } aec_ram_req_type;

  typedef struct packed {
    logic valid;
    logic [15:0] data;
  } aec_sample_type;

  // IMA ADPCM step sizes and index adjustments
  localparam logic [15:0] IMA_STEP [89] = '{
    16'h0007, 16'h0008, 16'h0009, 16'h000A, 16'h000B, 16'h000C, 16'h000D, 16'h000E,
    16'h0010, 16'h0011, 16'h0013, 16'h0015, 16'h0017, 16'h0019, 16'h001C, 16'h001F,
    16'h0022, 16'h0025, 16'h0029, 16'h002D, 16'h0032, 16'h0037, 16'h003C, 16'h0042,
    16'h0049, 16'h0050, 16'h0058, 16'h0061, 16'h006B, 16'h0076, 16'h0082, 16'h008F,
    16'h009D, 16'h00AD, 16'h00BE, 16'h00D1, 16'h00E6, 16'h00FD, 16'h0117, 16'h0133,
    16'h0151, 16'h0173, 16'h0198, 16'h01C1, 16'h01EE, 16'h0220, 16'h0256, 16'h0292,
    16'h02D4, 16'h031C, 16'h036C, 16'h03C3, 16'h0424, 16'h048E, 16'h0502, 16'h0583,
    16'h0610, 16'h06AB, 16'h0756, 16'h0812, 16'h08E0, 16'h09C3, 16'h0ABD, 16'h0BD0,
    16'h0CFF, 16'h0E4C, 16'h0FBA, 16'h114C, 16'h1307, 16'h14EE, 16'h1706, 16'h1954,
    16'h1BDC, 16'h1EA5, 16'h21B6, 16'h2515, 16'h28CA, 16'h2CDF, 16'h315B, 16'h364B,
    16'h3BB9, 16'h41B2, 16'h4844, 16'h4F7E, 16'h5771, 16'h602F, 16'h69CE, 16'h7462,
    16'h7FFF};
  localparam logic signed [8:0] IMA_IDX_ADJ [8] = '{
    -9'sh001, -9'sh001, -9'sh001, -9'sh001, 9'sh002, 9'sh004, 9'sh006, 9'sh008};
  localparam logic [6:0] IMA_IDX_MAX = 7'h58;

  // Byte-enable merge of a bus write into a stored word
  function automatic logic [31:0] be_merge(input logic [31:0] old_val,
                                           input logic [31:0] new_val,
                                           input logic [3:0] be);
    logic [31:0] res;
    res = old_val;
    for (int i = 0; i < 4; i++)
    begin
      if (be[i])
      begin
        res[i*8 +: 8] = new_val[i*8 +: 8];
      end
    end
    return res;
  endfunction

  // Linear volume: sample * vol / 255, so 0xFF passes unchanged and 0 mutes
  function automatic logic [15:0] scale_volume(input logic [15:0] s, input logic [7:0] v);
    logic signed [24:0] prod;
    logic signed [24:0] quot;
    prod = 25'($signed(s)) * $signed({17'h00000, v});
    quot = prod / 25'sh00000FF;
    return quot[15:0];
  endfunction

  function automatic logic [15:0] ulaw_decode(input logic [7:0] code);
    logic [7:0] u;
    logic [16:0] mag;
    u = ~code;
    mag = (17'({u[3:0], 3'h0}) + 17'h00084) << u[6:4];
    return u[7] ? 16'(17'h00084 - mag) : 16'(mag - 17'h00084);
  endfunction
endpackage

// ### rtl/aec_sample_decode.sv
// Sample decoder: linear, uLaw and IMA ADPCM, followed by volume scaling.
// Assumes one step pulse per output sample; restart clears ADPCM history.
`timescale 1ns/100ps
module aec_sample_decode (
  input wire logic sys_clk_in,
  input wire logic rst_b_in,
  input wire logic [1:0] format_in,
  input wire logic [7:0] byte_in,
  input wire logic nibble_hi_in,
  input wire logic step_in,
  input wire logic restart_in,
  input wire logic [7:0] volume_in,
  output aec_pkg::aec_sample_type sample_out
);
  logic signed [15:0] pred;
  logic [6:0] idx;
  logic signed [15:0] next_pred;
  logic [6:0] next_idx;
  aec_pkg::aec_sample_type next_sample;

  always_comb
  begin
    logic [3:0] code;
    logic [17:0] stp;
    logic [17:0] diff;
    logic signed [18:0] sum;
    logic signed [8:0] ix;
    logic [15:0] raw;
    code = nibble_hi_in ? byte_in[7:4] : byte_in[3:0];
    stp = {2'h0, aec_pkg::IMA_STEP[idx]};
    diff = stp >> 3;
    sum = 19'sh00000;
    ix = 9'sh000;
    raw = 16'h0000;
    next_pred = pred;
    next_idx = idx;
    next_sample.valid = step_in;
    next_sample.data = sample_out.data;
    if (code[2])
    begin
      diff = diff + stp;
    end
    if (code[1])
    begin
      diff = diff + (stp >> 1);
    end
    if (code[0])
    begin
      diff = diff + (stp >> 2);
    end
    // R8: format decides decoding
    unique case (format_in)
      aec_pkg::FMT_LINEAR: raw = {byte_in, 8'h00};
      aec_pkg::FMT_ULAW: raw = aec_pkg::ulaw_decode(byte_in);
      aec_pkg::FMT_ADPCM:
      begin
        sum = code[3] ? 19'(pred) - $signed({1'b0, diff}) : 19'(pred) + $signed({1'b0, diff});
        // Saturate instead of wrapping, wraps sound like loud clicks
        if (sum > 19'sh07FFF)
        begin
          sum = 19'sh07FFF;
        end
        else if (sum < -19'sh08000)
        begin
          sum = -19'sh08000;
        end
        ix = $signed({2'h0, idx}) + aec_pkg::IMA_IDX_ADJ[code[2:0]];
        if (ix < 9'sh000)
        begin
          ix = 9'sh000;
        end
        else if (ix > $signed({2'h0, aec_pkg::IMA_IDX_MAX}))
        begin
          ix = $signed({2'h0, aec_pkg::IMA_IDX_MAX});
        end
        raw = sum[15:0];
        if (step_in)
        begin
          next_pred = sum[15:0];
          next_idx = ix[6:0];
        end
      end
      // Undefined format plays silence
      aec_pkg::FMT_UNDEF: raw = 16'h0000;
    endcase
    if (step_in)
    begin
      // R4: playback volume
      // R13: linear scaling
      next_sample.data = aec_pkg::scale_volume(raw, volume_in);
    end
    if (restart_in)
    begin
      next_pred = 16'sh0000;
      next_idx = 7'h00;
    end
  end

  always_ff @(posedge sys_clk_in)
  begin
    if (!rst_b_in)
    begin
      pred <= 16'sh0000;
      idx <= 7'h00;
      sample_out <= '0;
    end
    else
    begin
      pred <= next_pred;
      idx <= next_idx;
      sample_out <= next_sample;
    end
  end
endmodule

// ### verif/tb_top.sv
// Bench for the audio control block: register bus, synth path, playback.
// Assumes the bench acts as bus master, sample RAM and synthesizer.
`timescale 1ns/100ps
module tb_top;
  logic sys_clk_in = 1'b0;
  logic rst_b_in = 1'b0;
  logic [7:0] avs_address_in = 8'h00;
  logic avs_read_in = 1'b0;
  logic avs_write_in = 1'b0;
  logic [31:0] avs_writedata_in = 32'h0;
  logic [3:0] avs_byteenable_in = 4'hF;
  logic [31:0] avs_readdata_out;
  logic avs_waitrequest_out;
  aec_pkg::aec_ram_req_type ram_req_out;
  logic ram_valid_in = 1'b0;
  logic [7:0] ram_data_in = 8'h00;
  logic [7:0] synth_effect_out;
  logic [7:0] synth_note_out;
  logic synth_play_out;
  logic synth_busy_in = 1'b0;
  logic synth_sample_valid_in = 1'b0;
  logic [15:0] synth_sample_in = 16'h0000;
  aec_pkg::aec_sample_type synth_sample_out;
  aec_pkg::aec_sample_type pb_sample_out;
  int mismatches = 0;
  int compares = 0;
  int plays = 0;
  logic [31:0] rd;
  logic [15:0] pb_q[$];
  logic [19:0] addr_q[$];
  logic [7:0] ra[8] = '{8'h80, 8'h84, 8'h88, 8'hC4, 8'hC8, 8'hCC, 8'hC0, 8'h90};
  logic [31:0] rv[8] = '{32'hFF, 32'hFF, 32'h0, 32'h0, 32'h0, 32'h0, 32'h1F40, 32'h0};

  aec_audio_ctrl u_dut (
    .sys_clk_in(sys_clk_in),
    .rst_b_in(rst_b_in),
    .avs_address_in(avs_address_in),
    .avs_read_in(avs_read_in),
    .avs_write_in(avs_write_in),
    .avs_writedata_in(avs_writedata_in),
    .avs_byteenable_in(avs_byteenable_in),
    .avs_readdata_out(avs_readdata_out),
    .avs_waitrequest_out(avs_waitrequest_out),
    .ram_req_out(ram_req_out),
    .ram_valid_in(ram_valid_in),
    .ram_data_in(ram_data_in),
    .synth_effect_out(synth_effect_out),
    .synth_note_out(synth_note_out),
    .synth_play_out(synth_play_out),
    .synth_busy_in(synth_busy_in),
    .synth_sample_valid_in(synth_sample_valid_in),
    .synth_sample_in(synth_sample_in),
    .synth_sample_out(synth_sample_out),
    .pb_sample_out(pb_sample_out)
  );

  initial
  begin
    forever #12.5 sys_clk_in = ~sys_clk_in;
  end

  // RAM answers one cycle late; data lines scramble once released
  always @(posedge sys_clk_in)
  begin
    if (synth_play_out === 1'b1) plays++;
    if (pb_sample_out.valid === 1'b1) pb_q.push_back(pb_sample_out.data);
    if (ram_req_out.req === 1'b1 && !ram_valid_in)
    begin
      ram_valid_in <= 1'b1;
      ram_data_in <= ram_req_out.addr[7:0];
      addr_q.push_back(ram_req_out.addr);
    end
    else
    begin
      ram_valid_in <= 1'b0;
      ram_data_in <= ~ram_data_in;
    end
  end

  task automatic close_out();
    $display("compares %0d, mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask

  // Request held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk_in);
    avs_address_in <= a;
    avs_writedata_in <= d;
    avs_write_in <= wr;
    avs_read_in <= ~wr;
    do
    begin
      @(posedge sys_clk_in);
    end
    while (avs_waitrequest_out !== 1'b0);
    rd = avs_readdata_out;
    avs_write_in <= 1'b0;
    avs_read_in <= 1'b0;
  endtask

  task automatic wait_idle();
    do
    begin
      bus(1'b0, 8'hCC, 32'h0);
    end
    while (rd[0] !== 1'b0);
  endtask

  task automatic syn(input logic [7:0] vol, input logic [15:0] s, input logic [15:0] e);
    bus(1'b1, 8'h84, {24'h0, vol});
    synth_sample_in <= s;
    synth_sample_valid_in <= 1'b1;
    @(posedge sys_clk_in);
    synth_sample_valid_in <= 1'b0;
    @(posedge sys_clk_in);
    chk("synth valid", {31'h0, synth_sample_out.valid}, 32'h1);
    chk("synth sample", {16'h0, synth_sample_out.data}, {16'h0, e});
  endtask

  task automatic play(input logic [1:0] fmt, input logic [7:0] vol, input logic [19:0] len,
                      input logic [15:0] e0, input logic [15:0] e1);
    bus(1'b1, 8'hC4, {30'h0, fmt});
    bus(1'b1, 8'h80, {24'h0, vol});
    bus(1'b1, 8'hB8, {12'h0, len});
    pb_q.delete();
    addr_q.delete();
    bus(1'b1, 8'hCC, 32'h0);
    bus(1'b0, 8'hCC, 32'h0);
    chk("busy flag", rd, 32'h1);
    wait_idle();
    chk("sample count", 32'(pb_q.size()), 32'h2);
    chk("first fetch", {12'h0, addr_q[0]}, 32'h10);
    chk("sample 0", {16'h0, pb_q[0]}, {16'h0, e0});
    chk("sample 1", {16'h0, pb_q[1]}, {16'h0, e1});
    bus(1'b0, 8'hBC, 32'h0);
    chk("read pointer", rd, 32'h10 + {12'h0, len});
  endtask

  initial
  begin
    repeat (2) @(posedge sys_clk_in);
    rst_b_in <= 1'b1;
    for (int i = 0; i < 8; i++)
    begin
      bus(1'b0, ra[i], 32'h0);
      chk("reset value", rd, rv[i]);
    end
    bus(1'b1, 8'h88, 32'hFFFF1234);
    @(posedge sys_clk_in);
    chk("effect", {24'h0, synth_effect_out}, 32'h34);
    chk("note", {24'h0, synth_note_out}, 32'h12);
    bus(1'b0, 8'h88, 32'h0);
    chk("sound select", rd, 32'h1234);
    avs_byteenable_in <= 4'h1;
    bus(1'b1, 8'h88, 32'hFFFF0056);
    avs_byteenable_in <= 4'hF;
    @(posedge sys_clk_in);
    chk("lane effect", {24'h0, synth_effect_out}, 32'h56);
    chk("lane note", {24'h0, synth_note_out}, 32'h12);
    bus(1'b1, 8'h8C, 32'h0);
    repeat (3) @(posedge sys_clk_in);
    chk("play pulses", 32'(plays), 32'h1);
    synth_busy_in <= 1'b1;
    bus(1'b0, 8'h8C, 32'h0);
    chk("synth busy", rd, 32'h1);
    synth_busy_in <= 1'b0;
    bus(1'b0, 8'h8C, 32'h0);
    chk("synth idle", rd, 32'h0);
    syn(8'h80, 16'h1000, 16'h0808);
    syn(8'h00, 16'h1000, 16'h0000);
    syn(8'hFF, 16'h8000, 16'h8000);
    bus(1'b1, 8'hC0, 32'hFFFF);
    bus(1'b1, 8'hB4, 32'h10);
    play(2'h0, 8'hFF, 20'h2, 16'h1000, 16'h1100);
    play(2'h0, 8'h80, 20'h2, 16'h0808, 16'h0888);
    play(2'h0, 8'h00, 20'h2, 16'h0000, 16'h0000);
    play(2'h1, 8'hFF, 20'h2, 16'hC184, 16'hC384);
    play(2'h2, 8'hFF, 20'h1, 16'h0000, 16'h0001);
    play(2'h3, 8'hFF, 20'h2, 16'h0000, 16'h0000);
    bus(1'b1, 8'hC8, 32'h1);
    bus(1'b1, 8'hC4, 32'h0);
    addr_q.delete();
    bus(1'b1, 8'hCC, 32'h1);
    while (addr_q.size() < 3)
    begin
      @(posedge sys_clk_in);
    end
    chk("loop fetch", {12'h0, addr_q[2]}, 32'h10);
    bus(1'b1, 8'hC8, 32'h0);
    wait_idle();
    chk("fetches", 32'(addr_q.size()), 32'h4);
    close_out();
  end

  // Whole run needs about 10000 cycles
  initial
  begin
    #2000000;
    mismatches++;
    close_out();
  end
endmodule
